/* File: src/rta_pkg.sv */
// Purpose: Constants for the calendar alarm and periodic flag block
// Assumes: Registers reached over AHB-Lite, one 32-bit word per index
// Notes: Byte address of a register is four times its index
// Operation
// - Compare valid enabled alarm fields against time
// - Minute alarm: bit7 disable, BCD 00-59
// - Hour alarm: bit7 disable, 12h/24h BCD hours
// - Day alarm: bit7 disable, BCD 01-31
// - Weekday alarm: bit7 disable, code 0-6
// - Alarm flag sets on each entry into a full match
// - Flag sticks; clears only when the host writes zero to it
// - Disabled alarm fields excluded from match
// - Flag writes AND with current value
// - Control register bit layout of flags, enables
// - Bit 4 selects pulse or level interrupt
// - Second enable overrides minute enable; minute ticks count only with bit 7 clear
// - Periodic flag sets on enabled counter tick
// - Periodic pulse every period regardless flag
// - Periodic flag readable and clearable by host
// - Hour format select governs hour alarm meaning
// - Current minutes are BCD 00-59
`default_nettype none
package rta_pkg;
  // Register indices
  localparam logic [7:0] RTA_IDX_CTRL = 8'h01;
  localparam logic [7:0] RTA_IDX_AMIN = 8'h09;
  localparam logic [7:0] RTA_IDX_AHOUR = 8'h0a;
  localparam logic [7:0] RTA_IDX_ADAY = 8'h0b;
  localparam logic [7:0] RTA_IDX_AWDAY = 8'h0c;
  localparam logic [7:0] RTA_IDX_HFMT = 8'h10;
  localparam int RTA_IDX_SHIFT = 2;
  // Control register fields
  localparam int RTA_B_SECEN = 7;
  localparam int RTA_B_MINEN = 6;
  localparam int RTA_B_PFLAG = 5;
  localparam int RTA_B_PULSE = 4;
  localparam int RTA_B_AFLAG = 3;
  localparam int RTA_B_CFLAG = 2;
  localparam int RTA_B_AIE = 1;
  localparam int RTA_B_CIE = 0;
  // Alarm register fields
  localparam int RTA_B_DIS = 7;
  localparam int RTA_B_PM = 5;
  // Reset values
  localparam logic [7:0] RTA_CTRL_RST = 8'h00;
  localparam logic [7:0] RTA_ALARM_RST = 8'h80;
  // Tick selection codes
  localparam logic [1:0] RTA_TICK_OFF = 2'h0;
  localparam logic [1:0] RTA_TICK_MIN = 2'h1;
  // AHB constants
  localparam logic [1:0] RTA_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RTA_HTRANS_SEQ = 2'h3;
endpackage
`default_nettype wire

/* File: src/rta_alarm_match.sv */
// Purpose: Combinational compare of alarm fields against current time
// Assumes: Time inputs are BCD with unused bits zero
// Notes: An enabled field holding an invalid value never matches
`default_nettype none
module rta_alarm_match (
  // Alarm registers
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_day,
  input wire logic [7:0] alarm_wday,
  input wire logic hour_12,
  // Current time
  input wire logic [6:0] now_min,
  input wire logic [5:0] now_hour,
  input wire logic [5:0] now_day,
  input wire logic [2:0] now_wday,
  // Result
  output logic match,
  output logic any_enabled
);
  import rta_pkg::*;

  // BCD value check within lo..hi
  function automatic logic bcd_ok(input logic [6:0] v, input logic [6:0] lo,
                                  input logic [6:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  logic [3:0] dis;
  logic [3:0] hit;
  logic hour_ok;

  // Disable bits of all four fields
  assign dis = {alarm_min[RTA_B_DIS], alarm_hour[RTA_B_DIS], alarm_day[RTA_B_DIS],
                alarm_wday[RTA_B_DIS]};

  // Hour field validity depends on format
  always_comb begin
    if (hour_12) begin
      hour_ok = bcd_ok({2'h0, alarm_hour[4:0]}, 7'h01, 7'h12);
    end else begin
      hour_ok = bcd_ok({1'b0, alarm_hour[5:0]}, 7'h00, 7'h23);
    end
  end

  // Per-field hits, each forced true when disabled
  assign hit[3] = dis[3] | (bcd_ok(alarm_min[6:0], 7'h00, 7'h59) &&
                  alarm_min[6:0] == now_min);
  assign hit[2] = dis[2] | (hour_ok && alarm_hour[5:0] == now_hour);
  assign hit[1] = dis[1] | (bcd_ok({1'b0, alarm_day[5:0]}, 7'h01, 7'h31) &&
                  alarm_day[5:0] == now_day);
  assign hit[0] = dis[0] | (alarm_wday[2:0] <= 3'h6 &&
                  alarm_wday[2:0] == now_wday);

  // Full match needs at least one enabled field
  assign any_enabled = ~&dis;
  assign match = &hit & any_enabled;
endmodule
`default_nettype wire

/* File: src/rta_top.sv */
// Purpose: Alarm compare, periodic tick flag and shared flag register
// Assumes: Tick and countdown inputs are one-cycle pulses on CORE_CLK
// Notes: Registers sit on AHB-Lite with zero wait states
//
// Our own choice: register access over AHB-Lite.
`default_nettype none
module rta_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Current time from the timekeeping counters
  input wire logic [6:0] NOW_MIN,
  input wire logic [5:0] NOW_HOUR,
  input wire logic [5:0] NOW_DAY,
  input wire logic [2:0] NOW_WDAY,
  // Counter increment and countdown events
  input wire logic SEC_TICK,
  input wire logic MIN_TICK,
  input wire logic COUNTDOWN_EVENT,
  // Flag and control state to the interrupt logic
  output logic ALARM_FLAG,
  output logic PERIODIC_FLAG,
  output logic COUNTDOWN_FLAG,
  output logic PERIODIC_PULSE,
  output logic IRQ_PULSE_OR_LEVEL_SELECT,
  output logic ALARM_IRQ_ENABLE,
  output logic COUNTDOWN_IRQ_ENABLE,
  output logic HOUR_12_MODE
);
  import rta_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] amin_r;
  logic [7:0] ahour_r;
  logic [7:0] aday_r;
  logic [7:0] awday_r;
  logic hfmt_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic match;
  logic any_en;
  logic match_prev_r;
  logic alarm_set;
  logic per_set;
  logic [1:0] tick_sel;
  logic addr_ok;
  logic [7:0] rd_val;
  logic [7:0] ctrl_nxt;
  logic ctrl_wr;

  // Address phase accepted
  assign addr_ok = HSEL && HREADY && (HTRANS == RTA_HTRANS_NONSEQ || HTRANS == RTA_HTRANS_SEQ);

  // Compare unit
  rta_alarm_match u_match (
    .alarm_min(amin_r),
    .alarm_hour(ahour_r),
    .alarm_day(aday_r),
    .alarm_wday(awday_r),
    .hour_12(hfmt_r),
    .now_min(NOW_MIN),
    .now_hour(NOW_HOUR),
    .now_day(NOW_DAY),
    .now_wday(NOW_WDAY),
    .match(match),
    .any_enabled(any_en)
  );

  // Previous match level for edge detection
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      match_prev_r <= 1'b0;
    end else begin
      match_prev_r <= match;
    end
  end

  // Alarm event only on entry into a match
  assign alarm_set = match && !match_prev_r && any_en;

  // Tick decoding from the two enable bits
  assign tick_sel = {ctrl_r[RTA_B_SECEN], ctrl_r[RTA_B_MINEN]};
  assign per_set = (tick_sel == RTA_TICK_MIN && MIN_TICK) ||
                   (tick_sel[1] && SEC_TICK);

  // Pending write captured in address phase
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_idx_r <= HADDR[RTA_IDX_SHIFT +: 8];
      end
    end
  end

  assign ctrl_wr = wr_pend_r && wr_idx_r == RTA_IDX_CTRL && HADDR[1:0] == 2'h0;

  // Control register: plain bits load, flags AND on write, set wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt[RTA_B_SECEN] = HWDATA[RTA_B_SECEN];
      ctrl_nxt[RTA_B_MINEN] = HWDATA[RTA_B_MINEN];
      ctrl_nxt[RTA_B_PULSE] = HWDATA[RTA_B_PULSE];
      ctrl_nxt[RTA_B_AIE] = HWDATA[RTA_B_AIE];
      ctrl_nxt[RTA_B_CIE] = HWDATA[RTA_B_CIE];
      ctrl_nxt[RTA_B_PFLAG] = ctrl_r[RTA_B_PFLAG] & HWDATA[RTA_B_PFLAG];
      ctrl_nxt[RTA_B_AFLAG] = ctrl_r[RTA_B_AFLAG] & HWDATA[RTA_B_AFLAG];
      ctrl_nxt[RTA_B_CFLAG] = ctrl_r[RTA_B_CFLAG] & HWDATA[RTA_B_CFLAG];
    end
    if (per_set) begin
      ctrl_nxt[RTA_B_PFLAG] = 1'b1;
    end
    if (alarm_set) begin
      ctrl_nxt[RTA_B_AFLAG] = 1'b1;
    end
    if (COUNTDOWN_EVENT) begin
      ctrl_nxt[RTA_B_CFLAG] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_r <= RTA_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Alarm and format registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      amin_r <= RTA_ALARM_RST;
      ahour_r <= RTA_ALARM_RST;
      aday_r <= RTA_ALARM_RST;
      awday_r <= RTA_ALARM_RST;
      hfmt_r <= 1'b0;
    end else if (wr_pend_r) begin
      if (wr_idx_r == RTA_IDX_AMIN) begin
        amin_r <= HWDATA[7:0];
      end else if (wr_idx_r == RTA_IDX_AHOUR) begin
        ahour_r <= HWDATA[7:0];
      end else if (wr_idx_r == RTA_IDX_ADAY) begin
        aday_r <= HWDATA[7:0];
      end else if (wr_idx_r == RTA_IDX_AWDAY) begin
        awday_r <= HWDATA[7:0];
      end else if (wr_idx_r == RTA_IDX_HFMT) begin
        hfmt_r <= HWDATA[0];
      end
    end
  end

  // Read decode, unmapped reads as zero
  always_comb begin
    if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_CTRL) begin
      rd_val = ctrl_r;
    end else if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_AMIN) begin
      rd_val = amin_r;
    end else if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_AHOUR) begin
      rd_val = ahour_r;
    end else if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_ADAY) begin
      rd_val = aday_r;
    end else if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_AWDAY) begin
      rd_val = awday_r;
    end else if (HADDR[RTA_IDX_SHIFT +: 8] == RTA_IDX_HFMT) begin
      rd_val = {7'h00, hfmt_r};
    end else begin
      rd_val = 8'h00;
    end
  end

  // Read data registered into the data phase
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      HRDATA <= {24'h00_0000, rd_val};
    end
  end

  // Zero-wait OKAY slave
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Registered outputs to the interrupt logic
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ALARM_FLAG <= 1'b0;
      PERIODIC_FLAG <= 1'b0;
      COUNTDOWN_FLAG <= 1'b0;
      PERIODIC_PULSE <= 1'b0;
      IRQ_PULSE_OR_LEVEL_SELECT <= 1'b0;
      ALARM_IRQ_ENABLE <= 1'b0;
      COUNTDOWN_IRQ_ENABLE <= 1'b0;
      HOUR_12_MODE <= 1'b0;
    end else begin
      ALARM_FLAG <= ctrl_nxt[RTA_B_AFLAG];
      PERIODIC_FLAG <= ctrl_nxt[RTA_B_PFLAG];
      COUNTDOWN_FLAG <= ctrl_nxt[RTA_B_CFLAG];
      PERIODIC_PULSE <= per_set;
      IRQ_PULSE_OR_LEVEL_SELECT <= ctrl_nxt[RTA_B_PULSE];
      ALARM_IRQ_ENABLE <= ctrl_nxt[RTA_B_AIE];
      COUNTDOWN_IRQ_ENABLE <= ctrl_nxt[RTA_B_CIE];
      HOUR_12_MODE <= hfmt_r;
    end
  end
endmodule
`default_nettype wire

/* File: verif/rta_host_model.sv */
// Purpose: Bus host issuing single word transfers
// Assumes: Zero or more wait states, OKAY only
// Notes: Write data is inverted once released
`default_nettype none
module rta_host_model (
  // Bus
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at start
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // Address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    if (w) hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    if (w) hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: verif/rta_top_properties.sv */
// Purpose: Temporal checks on flag and bus ports
// Assumes: One clock, synchronous reset
// Notes: Bound to the top module
`default_nettype none
module rta_top_properties (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  // Events and flags
  input wire logic SEC_TICK,
  input wire logic MIN_TICK,
  input wire logic COUNTDOWN_EVENT,
  input wire logic ALARM_FLAG,
  input wire logic PERIODIC_FLAG,
  input wire logic COUNTDOWN_FLAG,
  input wire logic PERIODIC_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_r;
  wire ap = HSEL && HREADY && HTRANS[1] && HADDR[9:2] == 8'h01;
  wire clr_a = wr_r && !HWDATA[3];
  wire clr_p = wr_r && !HWDATA[5];
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Data phase of a control write
  always_ff @(posedge CORE_CLK) begin
    wr_r <= ap && HWRITE;
  end
  AST_PULSE_CAUSE: assert property (PERIODIC_PULSE |->
    $past(SEC_TICK) || $past(MIN_TICK))
    else $error("pulse without tick");
  AST_PULSE_FLAG: assert property (PERIODIC_PULSE |-> PERIODIC_FLAG)
    else $error("pulse without flag");
  AST_PFLAG_RISE: assert property ($rose(PERIODIC_FLAG) |-> PERIODIC_PULSE)
    else $error("flag rose without pulse");
  AST_PFLAG_FALL: assert property ($fell(PERIODIC_FLAG) |-> $past(clr_p))
    else $error("periodic flag lost");
  AST_AFLAG_FALL: assert property ($fell(ALARM_FLAG) |-> $past(clr_a))
    else $error("alarm flag lost");
  AST_AFLAG_HOLD: assert property (ALARM_FLAG && !clr_a |=> ALARM_FLAG)
    else $error("alarm flag dropped");
  AST_CFLAG_SET: assert property (COUNTDOWN_EVENT |=> COUNTDOWN_FLAG)
    else $error("countdown flag not set");
  AST_RD_FLAGS: assert property (ap && !HWRITE |=>
    HRDATA[5] == $past(PERIODIC_FLAG) && HRDATA[3] == $past(ALARM_FLAG) &&
    HRDATA[31:8] == 24'h0)
    else $error("flag read mismatch");
  cover property ($rose(ALARM_FLAG));
  cover property ($fell(ALARM_FLAG));
  cover property (PERIODIC_PULSE && $past(PERIODIC_FLAG));
endmodule
bind rta_top rta_top_properties u_props (.CORE_CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE,
  .HREADY, .HWDATA, .HRDATA, .SEC_TICK, .MIN_TICK, .COUNTDOWN_EVENT, .ALARM_FLAG,
  .PERIODIC_FLAG, .COUNTDOWN_FLAG, .PERIODIC_PULSE);
`default_nettype wire

/* File: verif/rtc_alarm_periodic_irq_tb_top.sv */
// Purpose: Random and corner tests of alarm and periodic flags
// Assumes: Zero wait bus, 24 hour mode after reset
// Notes: Seeded random alarm values
`default_nettype none
module rtc_alarm_periodic_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rta_pkg::*;
  logic clk, srst, hrdy, hresp, hw, st, mt, cev, af, pf, cf, pp, sel, alarm_irq_enable, cie, h12;
  logic [31:0] ha, hwd, hrd, q;
  logic [1:0] htr;
  logic [6:0] nmin;
  logic [5:0] nhr, nday;
  logic [2:0] nwd;
  logic [7:0] v, m;
  int fails, checks, x;
  rta_top DUT (.CORE_CLK(clk), .SRST(srst), .HSEL(1'b1), .HADDR(ha), .HTRANS(htr),
    .HWRITE(hw), .HSIZE(3'h2), .HREADY(hrdy), .HWDATA(hwd), .HRDATA(hrd), .HREADYOUT(hrdy),
    .HRESP(hresp), .NOW_MIN(nmin), .NOW_HOUR(nhr), .NOW_DAY(nday), .NOW_WDAY(nwd),
    .SEC_TICK(st), .MIN_TICK(mt), .COUNTDOWN_EVENT(cev), .ALARM_FLAG(af), .PERIODIC_FLAG(pf),
    .COUNTDOWN_FLAG(cf), .PERIODIC_PULSE(pp), .IRQ_PULSE_OR_LEVEL_SELECT(sel),
    .ALARM_IRQ_ENABLE(alarm_irq_enable), .COUNTDOWN_IRQ_ENABLE(cie), .HOUR_12_MODE(h12));
  rta_host_model HOST (.clk(clk), .hready(hrdy), .hrdata(hrd), .haddr(ha), .htrans(htr),
    .hwrite(hw), .hwdata(hwd));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    HOST.xfer(1'b1, {22'h0, i, 2'h0}, {24'h0, d}, q);
    #1;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input string n);
    HOST.xfer(1'b0, {22'h0, i, 2'h0}, 32'h0, q);
    chk(n, q, {24'h0, e});
  endtask
  task automatic tick(input logic s, input logic t, input logic e);
    @(posedge clk);
    st <= s;
    mt <= t;
    @(posedge clk);
    st <= 1'b0;
    mt <= 1'b0;
    #1 chk("pulse", pp, e);
  endtask
  task automatic setnow(input int i, input logic [7:0] d);
    @(posedge clk);
    case (i)
      0: nmin <= d[6:0];
      1: nhr <= d[5:0];
      2: nday <= d[5:0];
      default: nwd <= d[2:0];
    endcase
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Legal BCD value of field i
  function automatic logic [7:0] enc(input int i, input int r);
    int y;
    y = (i == 0) ? r % 60 : (i == 1) ? r % 24 : (i == 2) ? r % 31 + 1 : r % 7;
    return 8'((y / 10) * 16 + y % 10);
  endfunction
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #200000;
    fails++;
    close_out;
  end
  // Main sequence
  initial begin
    {srst, st, mt, cev, nmin, nhr, nday, nwd} = {1'b1, 25'h0};
    x = $urandom(32'h06435902);
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(RTA_IDX_CTRL, 8'h00, "ctrl reset");
    for (int i = 0; i < 4; i++) rd(RTA_IDX_AMIN + 8'(i), 8'h80, "alarm reset");
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'h00, "unmapped");
    chk("resp", hresp, 0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      x = $urandom % 1000;
      v = enc(i, x);
      m = enc(i, x + 1);
      setnow(i, m);
      wr(RTA_IDX_AMIN + 8'(i), v);
      wr(RTA_IDX_CTRL, 8'h00);
      chk("alarm idle", af, 0);
      setnow(i, v);
      chk("alarm set", af, 1);
      wr(RTA_IDX_CTRL, 8'h24);
      setnow(i, v);
      chk("alarm held", af, 0);
      setnow(i, m);
      setnow(i, v);
      chk("alarm again", af, 1);
      wr(RTA_IDX_AMIN + 8'(i), v | 8'h80);
      rd(RTA_IDX_AMIN + 8'(i), v | 8'h80, "alarm read");
      wr(RTA_IDX_CTRL, 8'h00);
      setnow(i, m);
      setnow(i, v);
      chk("alarm off", af, 0);
    end
    wr(RTA_IDX_HFMT, 8'h01);
    // Format output follows the format register one cycle later
    @(posedge clk);
    #1;
    chk("hour mode", h12, 1);
    setnow(1, 8'h01);
    wr(RTA_IDX_AHOUR, 8'h21);
    setnow(1, 8'h21);
    chk("pm alarm", af, 1);
    $display("alarm test done");
    for (int s = 0; s < 4; s++) begin
      wr(RTA_IDX_CTRL, {s[1:0], 6'h0});
      tick(1'b1, 1'b0, s[1]);
      tick(1'b0, 1'b1, s == 1);
      chk("periodic flag", pf, s != 0);
      tick(s[1], s == 1, s != 0);
    end
    rd(RTA_IDX_CTRL, 8'he0, "ctrl tick");
    wr(RTA_IDX_CTRL, 8'hc0);
    chk("periodic clear", pf, 0);
    $display("periodic test done");
    @(posedge clk);
    cev <= 1'b1;
    @(posedge clk);
    cev <= 1'b0;
    wr(RTA_IDX_CTRL, 8'h17);
    chk("ctrl out", {sel, alarm_irq_enable, cie, cf}, 4'hf);
    rd(RTA_IDX_CTRL, 8'h17, "ctrl read");
    wr(RTA_IDX_CTRL, 8'h13);
    chk("countdown clear", cf, 0);
    $display("control test done");
    close_out;
  end
endmodule
`default_nettype wire
